// ### design/cam_top.sv
// Content-addressable memory: 32 entries of 32 bits with per-bit masking.
// Assumes user logic on core_clk drives writes and searches.
`timescale 1ns/1ns
`include "cam_cfg.svh"
module cam_top
  import cam_pkg::*;
#(
  parameter logic [`CAM_DEPTH*`CAM_WIDTH-1:0] INIT_DATA = '0,
  parameter logic [`CAM_DEPTH*`CAM_WIDTH-1:0] INIT_CARE = '1
) (
  // Clock and clears
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic                    local_clr_n,
  input  wire logic                    global_clr_n,
  // Write request
  input  wire logic                    wr_req,
  input  wire logic [`CAM_ADDR_W-1:0]  wr_addr,
  input  wire logic [`CAM_WIDTH-1:0]   wr_data,
  input  wire logic [`CAM_WIDTH-1:0]   wr_dont_care,
  output logic                         wr_busy,
  // Search request
  input  wire logic                    srch_req,
  input  wire logic                    srch_unencoded,
  input  wire logic [`CAM_WIDTH-1:0]   srch_data,
  // Results
  output logic                         match,
  output logic [`CAM_ADDR_W-1:0]       match_addr,
  output logic [`CAM_LINES-1:0]        match_lines,
  output logic                         result_valid,
  output logic                         result_second
);

  cam_state_s_t s_q;
  cam_state_s_t s_d;
  logic         clr_n;
  logic [`CAM_DEPTH-1:0] hits;
  logic [`CAM_ADDR_W-1:0] enc;

  // Any clear source sets the state to CAM_IDLE, zeroes the other registers and reloads data and care from INIT_DATA and INIT_CARE
  assign clr_n = reset_n & local_clr_n & global_clr_n;

  // Parallel compare against all entries
  always_comb begin
    hits = '0;
    for (int i = 0; i < `CAM_DEPTH; i++) begin
      hits[i] = ((s_q.data[i] ^ srch_data) & s_q.care[i]) == '0;
    end
  end

  // Lowest hit wins; with duplicates, the lowest matching entry is reported
  always_comb begin
    enc = '0;
    for (int i = `CAM_DEPTH - 1; i >= 0; i--) begin
      if (hits[i]) begin
        enc = i[`CAM_ADDR_W-1:0];
      end
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.res_valid  = 1'b0;
    s_d.res_second = 1'b0;
    case (s_q.state)
      CAM_IDLE: begin
        if (wr_req) begin
          s_d.wr_addr = wr_addr;
          s_d.wr_data = wr_data;
          s_d.wr_care = ~wr_dont_care;
          s_d.wr_busy = 1'b1;
          s_d.state   = CAM_WR_B;
        end else if (srch_req) begin
          s_d.match     = |hits;
          s_d.res_valid = 1'b1;
          if (srch_unencoded) begin
            s_d.lines    = hits[`CAM_LINES-1:0];
            s_d.hi_lines = hits[`CAM_DEPTH-1:`CAM_LINES];
            s_d.addr     = '0;
            s_d.state    = CAM_UNENC;
          end else begin
            s_d.addr  = enc;
            s_d.lines = '0;
          end
        end
      end
      CAM_WR_B: begin
        // Second write cycle stores the word
        s_d.data[s_q.wr_addr] = s_q.wr_data;
        if (&s_q.wr_care) begin
          s_d.care[s_q.wr_addr] = s_q.wr_care;
          s_d.wr_busy = 1'b0;
          s_d.state   = CAM_IDLE;
        end else begin
          s_d.state = CAM_WR_C;
        end
      end
      CAM_WR_C: begin
        // Third cycle loads the mask
        s_d.care[s_q.wr_addr] = s_q.wr_care;
        s_d.wr_busy = 1'b0;
        s_d.state   = CAM_IDLE;
      end
      CAM_UNENC: begin
        s_d.lines      = s_q.hi_lines;
        s_d.res_valid  = 1'b1;
        s_d.res_second = 1'b1;
        s_d.state      = CAM_IDLE;
      end
      default: s_d.state = CAM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge clr_n) begin
    if (!clr_n) begin
      s_q            <= '0;
      s_q.state      <= CAM_IDLE;
      s_q.data       <= INIT_DATA;
      s_q.care       <= INIT_CARE;
    end else begin
      s_q <= s_d;
    end
  end

  assign wr_busy       = s_q.wr_busy;
  assign match         = s_q.match;
  assign match_addr    = s_q.addr;
  assign match_lines   = s_q.lines;
  assign result_valid  = s_q.res_valid;
  assign result_second = s_q.res_second;

endmodule

// ### design/cam_cfg.svh
// Constants for the content-addressable memory block.
// Assumes inclusion by the package and the design module only.
`ifndef CAM_CFG_SVH
`define CAM_CFG_SVH
`define CAM_DEPTH        32
`define CAM_WIDTH        32
`define CAM_ADDR_W       5
`define CAM_LINES        16
`define CAM_WR_CYCLES    2
`define CAM_WR_DC_CYCLES 3
`endif

// ### design/cam_pkg.sv
// Types for the content-addressable memory block.
// Assumes cam_cfg.svh is on the include path.
`include "cam_cfg.svh"
package cam_pkg;
  typedef enum logic [3:0] {
    CAM_IDLE  = 4'b0001,
    CAM_WR_B  = 4'b0010,
    CAM_WR_C  = 4'b0100,
    CAM_UNENC = 4'b1000
  } cam_state_t;

  typedef struct packed {
    cam_state_t                         state;
    logic [`CAM_DEPTH-1:0][`CAM_WIDTH-1:0] data;
    logic [`CAM_DEPTH-1:0][`CAM_WIDTH-1:0] care;
    logic [`CAM_ADDR_W-1:0]             wr_addr;
    logic [`CAM_WIDTH-1:0]              wr_data;
    logic [`CAM_WIDTH-1:0]              wr_care;
    logic [`CAM_LINES-1:0]              hi_lines;
    logic                               wr_busy;
    logic                               match;
    logic [`CAM_ADDR_W-1:0]             addr;
    logic [`CAM_LINES-1:0]              lines;
    logic                               res_valid;
    logic                               res_second;
  } cam_state_s_t;
endpackage

// ### tb/cam_props.sv
// Port checker for cam_top, bound below.
`timescale 1ns/1ns
module cam_props (input wire logic core_clk, reset_n, wr_req, srch_req, srch_unencoded,
  input wire logic wr_busy, match, result_valid, result_second,
  input wire logic [31:0] wr_dont_care, input wire logic [4:0] match_addr,
  input wire logic [15:0] match_lines, input wire logic local_clr_n, global_clr_n);
  wire clr = reset_n && local_clr_n && global_clr_n;
  logic upend;
  // Requests in the first unencoded result cycle are refused by the block
  wire dc = |wr_dont_care, wt = wr_req && !wr_busy && !upend;
  wire sq = srch_req && !wr_req && !wr_busy && !upend;
  wire se = sq && !srch_unencoded, su = sq && srch_unencoded;
  always_ff @(posedge core_clk or negedge clr) begin
    if (!clr) begin
      upend <= 1'b0;
    end else begin
      upend <= su;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!clr);
  a_wr_len: assert property (wt && !dc |=> wr_busy ##1 !wr_busy) else $error("wr len");
  a_wr_dc: assert property (wt && dc |=> wr_busy[*2] ##1 !wr_busy) else $error("dc len");
  a_enc_res: assert property (se |=> result_valid && match_lines == 0) else $error("enc");
  a_unenc_two: assert property (su |=> !result_second ##1 result_second) else $error("u");
  a_res_src: assert property (result_valid |-> result_second || $past(sq)) else $error("r");
  a_hit_match: assert property (match_lines != 0 |-> match) else $error("hit");
  a_hi_addr: assert property (result_second |-> !match_addr && result_valid) else $error("h");
  a_busy_src: assert property ($rose(wr_busy) |-> $past(wt)) else $error("busy");
  c_unenc: cover property (su);
  c_mask: cover property (wt && dc);
  c_hit_hi: cover property (result_second && match);
endmodule
bind cam_top cam_props chk_u (.*);

// ### tb/cam_user.sv
// User logic model; one request at a time, data lines inverted on release.
`timescale 1ns/1ns
module cam_user (input wire logic core_clk, output logic wr_req, srch_req, srch_unencoded,
  output logic [4:0] wr_addr, output logic [31:0] wr_data, wr_dont_care, srch_data);
  initial {wr_req, srch_req, srch_unencoded, wr_addr, wr_data, wr_dont_care, srch_data} = '0;
  task automatic wr(logic [4:0] a, logic [31:0] d, m);
    {wr_req, wr_addr, wr_data, wr_dont_care} = {1'b1, a, d, m};
    @(posedge core_clk) #1;
    {wr_req, wr_data} = {1'b0, ~d};
    repeat (2) @(posedge core_clk) #1;
  endtask
  task automatic srch(logic [31:0] d, logic u);
    {srch_req, srch_data, srch_unencoded} = {1'b1, d, u};
    @(posedge core_clk) #1;
    {srch_req, srch_data} = {1'b0, ~d};
  endtask
endmodule

// ### tb/testbench.sv
// Bench for cam_top; cam_user drives requests, results judged here.
`timescale 1ns/1ns
module testbench;
  logic core_clk = 0, reset_n = 0, local_clr_n = 1, global_clr_n = 1, wr_req, srch_req;
  logic srch_unencoded, wr_busy, match, result_valid, result_second;
  logic [4:0] wr_addr, match_addr;
  logic [15:0] match_lines;
  logic [31:0] wr_data, wr_dont_care, srch_data;
  int fail_count = 0, comparisons = 0;
  cam_top dut_u (.*);
  cam_user user_u (.*);
  initial forever #10 core_clk = ~core_clk;
  task automatic chk(string n, logic [31:0] e, g);
    comparisons++;
    fail_count += g !== e;
    if (g !== e) $display("[ERR] %s exp %h got %h", n, e, g);
  endtask
  task t_enc;
    user_u.wr(12, 32'hC0DE_0001, 0);
    user_u.wr(31, 32'h1234_5678, 32'h0000_00FF);
    user_u.srch(32'hC0DE_0001, 0);
    chk("addr", 12, match_addr);
    chk("match", 1, match);
    chk("valid", 1, result_valid);
    user_u.srch(32'h1234_56AA, 0);
    chk("masked", 31, match_addr);
  endtask
  task t_unenc;
    user_u.wr(20, 32'hC0DE_0001, 0);
    user_u.srch(32'hC0DE_0001, 1);
    chk("lines lo", 16'h1000, match_lines);
    @(posedge core_clk) #1;
    chk("lines hi", 16'h0010, match_lines);
    chk("second", 1, result_second);
    global_clr_n = 0;
    @(posedge core_clk) #1;
    chk("cleared", 0, match);
    global_clr_n = 1;
    user_u.srch(32'h0000_0000, 1);
    chk("reloaded", 16'hFFFF, match_lines);
  endtask
  initial begin
    #91 reset_n = 1;
    t_enc;
    t_unenc;
    complete_run(0);
  end
  initial #20000 complete_run(1);
  task complete_run(int late);
    $display("comparisons %0d fail_count %0d", comparisons, fail_count + late);
    if (fail_count + late == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
endmodule
